// ### shared/audio_clock_params.svh
`ifndef AUDIO_CLOCK_PARAMS_SVH
`define AUDIO_CLOCK_PARAMS_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define IDX_CLOCK_CONTROL 6'h30
`define IDX_CTS_BYTE0 6'h31
`define IDX_CTS_BYTE1 6'h32
`define IDX_CTS_BYTE2 6'h33
`define IDX_N_BYTE0 6'h34
`define IDX_N_BYTE1 6'h35
`define IDX_N_TOP_FILTER 6'h36
`define IDX_FIFO_STATUS 6'h37

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BIT_FRAME_SELECT 7
`define FLD_MCLK_RATIO_HI 6
`define FLD_MCLK_RATIO_LO 5
`define FLD_REF_DIV_HI 4
`define FLD_REF_DIV_LO 3
`define FLD_CLEAN_HI 2
`define FLD_CLEAN_LO 1
`define BIT_CLOCK_MASTER 0
`define FLD_FILTER_HI 7
`define FLD_FILTER_LO 4
`define FLD_N_TOP_HI 3
`define FLD_N_TOP_LO 0
`define FLD_IN_FILL_HI 5
`define FLD_IN_FILL_LO 3
`define FLD_OUT_FILL_HI 2
`define FLD_OUT_FILL_LO 0

// ------------------------------------------------------------
// reset values and counts
// ------------------------------------------------------------
`define RESET_BYTE 8'h00
`define HALF_FRAME_LAST_64 5'h1f
`define HALF_FRAME_LAST_32 5'h0f
`define MCLK_LAST_X4 3'h3
`define MCLK_LAST_X2 3'h1
`define MCLK_LAST_X1 3'h0
`define MCLK_LAST_X8 3'h7
`define DIV_MASK_8 3'h7
`define DIV_MASK_4 3'h3
`define DIV_MASK_2 3'h1
`define FILL_FULL 3'h7

`endif

// ### shared/audio_clock_pkg.sv
package audio_clock_pkg;

    typedef enum logic [1:0] {
        REF_VCO_DIV8 = 2'h0,
        REF_VCO_DIV4 = 2'h1,
        REF_VCO_DIV2 = 2'h2,
        REF_AON = 2'h3
    } ref_source_type;

    typedef enum logic [1:0] {
        CLEAN_OFF = 2'h0,
        CLEAN_RATIO1 = 2'h1,
        CLEAN_RATIO2 = 2'h2,
        CLEAN_RATIO4 = 2'h3
    } clean_mode_type;

    typedef enum logic [1:0] {
        MCLK_X4 = 2'h0,
        MCLK_X2 = 2'h1,
        MCLK_X1 = 2'h2,
        MCLK_X8 = 2'h3
    } mclk_ratio_type;

endpackage : audio_clock_pkg

// ### hdl/audio_clock_gen_cleaner.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "audio_clock_params.svh"
// Contract
// - frame select bit: 0 gives 64 bit clocks per frame, 1 gives 32
// - master clock to bit clock ratio: 00=4, 01=2, 10=1, 11=8
// - nonzero clean mode cleans the source clock; ratio 1, 2 or 4
// - master bit drives bit clock and word select and enables generation
// - 24-bit cts in three bytes; nonzero cts regenerates audio clock
// - 20-bit n in two bytes plus low nibble, used with cts
// - upper nibble sets loop filter shift, feedback divided by 2^shift
// - status reports input and output fifo fill in 3-bit fields
module audio_clock_gen_cleaner
    import audio_clock_pkg::*;
#(
    parameter int EST_W = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // clock sources
    input wire logic link_pll_vco_clock,
    input wire logic always_on_oscillator,
    // audio port pins
    input wire logic bit_clock_in,
    output logic bit_clock_out,
    output logic bit_clock_oe,
    input wire logic word_select_pin_in,
    output logic word_select_pin_out,
    output logic word_select_pin_oe,
    output logic master_clock_out
);

    // --------------------------------------------------------
    // functions
    // --------------------------------------------------------
    function automatic logic is_reg(input logic [7:0] addr,
                                    input logic [5:0] idx);
        is_reg = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
    endfunction : is_reg

    function automatic logic [2:0] mclk_last_of(input mclk_ratio_type r);
        case (r)
            MCLK_X4: mclk_last_of = `MCLK_LAST_X4;
            MCLK_X2: mclk_last_of = `MCLK_LAST_X2;
            MCLK_X1: mclk_last_of = `MCLK_LAST_X1;
            default: mclk_last_of = `MCLK_LAST_X8;
        endcase
    endfunction : mclk_last_of

    function automatic logic [2:0] div_mask_of(input ref_source_type s);
        case (s)
            REF_VCO_DIV8: div_mask_of = `DIV_MASK_8;
            REF_VCO_DIV4: div_mask_of = `DIV_MASK_4;
            default: div_mask_of = `DIV_MASK_2;
        endcase
    endfunction : div_mask_of

    // --------------------------------------------------------
    // registers and apb decode
    // --------------------------------------------------------
    logic [7:0] audio_clock_control;
    logic [23:0] regen_cts;
    logic [19:0] regen_n;
    logic [3:0] loop_filter_shift;
    logic [2:0] cleaner_input_fill;
    logic [2:0] cleaner_output_fill;

    wire setup = psel && !penable;
    wire access = psel && penable && pready;
    wire mapped = paddr[1:0] == 2'h0
        && paddr[7:2] >= `IDX_CLOCK_CONTROL
        && paddr[7:2] <= `IDX_FIFO_STATUS;
    wire write_now = access && pwrite && mapped;
    wire [7:0] status_byte = {2'h0, cleaner_input_fill,
        cleaner_output_fill};
    wire [7:0] read_byte =
        is_reg(paddr, `IDX_CLOCK_CONTROL) ? audio_clock_control :
        is_reg(paddr, `IDX_CTS_BYTE0) ? regen_cts[7:0] :
        is_reg(paddr, `IDX_CTS_BYTE1) ? regen_cts[15:8] :
        is_reg(paddr, `IDX_CTS_BYTE2) ? regen_cts[23:16] :
        is_reg(paddr, `IDX_N_BYTE0) ? regen_n[7:0] :
        is_reg(paddr, `IDX_N_BYTE1) ? regen_n[15:8] :
        is_reg(paddr, `IDX_N_TOP_FILTER) ?
            {loop_filter_shift, regen_n[19:16]} :
        is_reg(paddr, `IDX_FIFO_STATUS) ? status_byte : `RESET_BYTE;

    // answer one cycle after setup: pready rises in the first access cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite) ? {24'h0, read_byte} : 32'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            audio_clock_control <= `RESET_BYTE;
            regen_cts <= 24'h0;
            regen_n <= 20'h0;
            loop_filter_shift <= 4'h0;
        end else if (write_now) begin
            case (paddr[7:2])
                `IDX_CLOCK_CONTROL: audio_clock_control <= pwdata[7:0];
                `IDX_CTS_BYTE0: regen_cts[7:0] <= pwdata[7:0];
                `IDX_CTS_BYTE1: regen_cts[15:8] <= pwdata[7:0];
                `IDX_CTS_BYTE2: regen_cts[23:16] <= pwdata[7:0];
                `IDX_N_BYTE0: regen_n[7:0] <= pwdata[7:0];
                `IDX_N_BYTE1: regen_n[15:8] <= pwdata[7:0];
                `IDX_N_TOP_FILTER: begin
                    regen_n[19:16] <= pwdata[`FLD_N_TOP_HI:`FLD_N_TOP_LO];
                    loop_filter_shift <=
                        pwdata[`FLD_FILTER_HI:`FLD_FILTER_LO];
                end
                default: ;
            endcase
        end
    end

    wire clock_master = audio_clock_control[`BIT_CLOCK_MASTER];
    wire frame_select = audio_clock_control[`BIT_FRAME_SELECT];
    wire ref_source_type ref_sel = ref_source_type'(
        audio_clock_control[`FLD_REF_DIV_HI:`FLD_REF_DIV_LO]);
    wire clean_mode_type clean_mode = clean_mode_type'(
        audio_clock_control[`FLD_CLEAN_HI:`FLD_CLEAN_LO]);
    wire mclk_ratio_type mclk_ratio = mclk_ratio_type'(
        audio_clock_control[`FLD_MCLK_RATIO_HI:`FLD_MCLK_RATIO_LO]);

    // --------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------
    // sampling at sys_clk only tracks sources well below half its rate
    logic [1:0] vco_sync, aon_sync, bclk_sync, wsel_sync;
    logic vco_last, aon_last, bclk_last;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            vco_sync <= 2'h0;
            aon_sync <= 2'h0;
            bclk_sync <= 2'h0;
            wsel_sync <= 2'h0;
            vco_last <= 1'b0;
            aon_last <= 1'b0;
            bclk_last <= 1'b0;
        end else begin
            vco_sync <= {vco_sync[0], link_pll_vco_clock};
            aon_sync <= {aon_sync[0], always_on_oscillator};
            bclk_sync <= {bclk_sync[0], bit_clock_in};
            wsel_sync <= {wsel_sync[0], word_select_pin_in};
            vco_last <= vco_sync[1];
            aon_last <= aon_sync[1];
            bclk_last <= bclk_sync[1];
        end
    end

    wire vco_rise = vco_sync[1] && !vco_last;
    wire aon_rise = aon_sync[1] && !aon_last;
    wire bclk_rise = bclk_sync[1] && !bclk_last;

    // --------------------------------------------------------
    // reference divider and n/cts regeneration
    // --------------------------------------------------------
    logic [2:0] div_count;
    logic [24:0] regen_acc;

    wire [2:0] div_mask = div_mask_of(ref_sel);
    wire div_wrap = vco_rise && ((div_count & div_mask) == div_mask);
    wire ref_tick = (ref_sel == REF_AON) ? aon_rise : div_wrap;

    // n larger than cts cannot be followed: one audio tick per reference
    wire regen_on = regen_cts != 24'h0;
    wire [24:0] regen_sum = regen_acc + {5'h0, regen_n};
    wire regen_wrap = regen_sum >= {1'b0, regen_cts};
    wire regen_tick = regen_on && ref_tick && regen_wrap;
    wire [24:0] next_acc = regen_wrap ? regen_sum - {1'b0, regen_cts}
        : regen_sum;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            div_count <= 3'h0;
        end else if (vco_rise) begin
            div_count <= div_count + 3'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || !regen_on) begin
            regen_acc <= 25'h0;
        end else if (ref_tick) begin
            regen_acc <= next_acc;
        end
    end

    wire src_tick = clock_master ? (regen_on ? regen_tick : ref_tick)
        : bclk_rise;

    // --------------------------------------------------------
    // clock cleaner
    // --------------------------------------------------------
    logic [EST_W-1:0] gap_count, period_est, pace_count;
    logic [1:0] sub_count;

    wire clean_on = clean_mode != CLEAN_OFF;
    wire signed [EST_W:0] est_error = $signed({1'b0, gap_count})
        - $signed({1'b0, period_est});
    wire signed [EST_W:0] est_step = est_error >>> loop_filter_shift;
    wire [EST_W-1:0] next_est = period_est + est_step[EST_W-1:0];
    wire [1:0] ratio_log = clean_mode - 2'h1;
    wire [EST_W-1:0] out_step = period_est >> ratio_log;
    wire [1:0] sub_limit = 2'((3'h1 << ratio_log) - 3'h1);
    wire in_empty = cleaner_input_fill == 3'h0;
    wire out_full = cleaner_output_fill == `FILL_FULL;
    wire clean_tick = clean_on && !in_empty && !out_full
        && pace_count >= out_step;
    wire in_pop = clean_tick && sub_count == sub_limit;
    wire in_push = clean_on && src_tick
        && cleaner_input_fill != `FILL_FULL;
    wire out_pop = cleaner_output_fill != 3'h0;
    wire gen_tick = clean_on ? out_pop : src_tick;

    // filtered period, step shifted by filter
    always_ff @(posedge sys_clk) begin
        if (srst || !clean_on) begin
            gap_count <= '0;
            period_est <= '0;
        end else if (src_tick) begin
            gap_count <= '0;
            period_est <= next_est;
        end else if (gap_count != '1) begin
            gap_count <= gap_count + {{(EST_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || !clean_on) begin
            pace_count <= '0;
            sub_count <= 2'h0;
            cleaner_input_fill <= 3'h0;
            cleaner_output_fill <= 3'h0;
        end else begin
            pace_count <= clean_tick ? '0
                : pace_count + {{(EST_W-1){1'b0}}, pace_count != '1};
            if (clean_tick) begin
                sub_count <= in_pop ? 2'h0 : sub_count + 2'h1;
            end
            cleaner_input_fill <= cleaner_input_fill
                + {2'h0, in_push} - {2'h0, in_pop};
            cleaner_output_fill <= cleaner_output_fill
                + {2'h0, clean_tick} - {2'h0, out_pop};
        end
    end

    // --------------------------------------------------------
    // port clock generation
    // --------------------------------------------------------
    logic [2:0] mclk_count;
    logic [4:0] bit_count;

    wire [2:0] mclk_last = mclk_last_of(mclk_ratio);
    wire bclk_edge = gen_tick && mclk_count == mclk_last;
    wire bclk_fall = bclk_edge && bit_clock_out;
    wire [4:0] half_last = frame_select ? `HALF_FRAME_LAST_32
        : `HALF_FRAME_LAST_64;
    wire word_edge = bclk_fall && bit_count == half_last;

    // bit clock from master clock ticks
    always_ff @(posedge sys_clk) begin
        if (srst || !clock_master) begin
            master_clock_out <= 1'b0;
            bit_clock_out <= 1'b0;
            mclk_count <= 3'h0;
            bit_count <= 5'h0;
        end else if (gen_tick) begin
            master_clock_out <= !master_clock_out;
            mclk_count <= bclk_edge ? 3'h0 : mclk_count + 3'h1;
            bit_clock_out <= bclk_edge ? !bit_clock_out : bit_clock_out;
            if (bclk_fall) begin
                bit_count <= word_edge ? 5'h0 : bit_count + 5'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            word_select_pin_out <= 1'b0;
            bit_clock_oe <= 1'b0;
            word_select_pin_oe <= 1'b0;
        end else begin
            bit_clock_oe <= clock_master;
            word_select_pin_oe <= clock_master;
            if (!clock_master) begin
                word_select_pin_out <= wsel_sync[1];
            end else if (word_edge) begin
                word_select_pin_out <= !word_select_pin_out;
            end
        end
    end

    // --------------------------------------------------------
    // assertions
    // --------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    property p_half_frame;
        clock_master && $past(clock_master)
            && word_select_pin_out != $past(word_select_pin_out)
            |-> $past(bit_count) == $past(half_last);
    endproperty
    a_half_frame: assert property (p_half_frame)
        else $error("word select toggled at wrong bit count");

    property p_mclk_ratio;
        clock_master && $past(clock_master)
            && bit_clock_out != $past(bit_clock_out)
            |-> $past(mclk_count) == $past(mclk_last) && $past(gen_tick);
    endproperty
    a_mclk_ratio: assert property (p_mclk_ratio)
        else $error("bit clock toggled off ratio");

    property p_ref_div;
        ref_tick && ref_sel == REF_VCO_DIV8 |-> div_count == `DIV_MASK_8;
    endproperty
    a_ref_div: assert property (p_ref_div)
        else $error("divide by eight reference tick early");

    property p_clean_off;
        (clean_mode == CLEAN_OFF) [*8] |-> cleaner_output_fill == 3'h0;
    endproperty
    a_clean_off: assert property (p_clean_off)
        else $error("output fifo filled while cleaning off");

    property p_pin_dir;
        ##1 $stable(clock_master) |-> bit_clock_oe == clock_master
            && word_select_pin_oe == clock_master;
    endproperty
    a_pin_dir: assert property (p_pin_dir)
        else $error("pin enable does not follow master bit");

    property p_regen_needs_cts;
        !regen_on |=> regen_acc == 25'h0;
    endproperty
    a_regen_needs_cts: assert property (p_regen_needs_cts)
        else $error("regeneration ran with zero cts");

    property p_n_accumulate;
        regen_on && ref_tick && !regen_wrap
            |=> regen_acc == $past(regen_acc) + {5'h0, $past(regen_n)};
    endproperty
    a_n_accumulate: assert property (p_n_accumulate)
        else $error("accumulator did not add n");

    property p_filter_zero;
        clean_on && src_tick && loop_filter_shift == 4'h0
            ##1 clean_on |-> period_est == $past(gap_count);
    endproperty
    a_filter_zero: assert property (p_filter_zero)
        else $error("zero shift did not take full measurement");

    property p_status_read;
        setup && !pwrite && is_reg(paddr, `IDX_FIFO_STATUS)
            |=> prdata == {26'h0, $past(cleaner_input_fill),
                $past(cleaner_output_fill)};
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read returned wrong fill levels");

    property p_reset_zero;
        $past(srst) |-> audio_clock_control == `RESET_BYTE
            && regen_cts == 24'h0 && regen_n == 20'h0
            && !bit_clock_oe && !word_select_pin_oe;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("registers not zero after reset");

endmodule : audio_clock_gen_cleaner

// ### bench/audio_peer_model.sv
`timescale 1ns/1ps
module audio_peer_model #(
    parameter int VCO_HALF = 75,
    parameter int AON_HALF = 95,
    parameter int BCLK_HALF = 200
) (
    // port direction seen on the pins
    input wire logic bit_clock_oe,
    input wire logic word_select_pin_oe,
    // reference clocks
    output logic link_pll_vco_clock,
    output logic always_on_oscillator,
    // far side pin drive
    output logic peer_bit_clock,
    output logic peer_word_select
);
    int falls;

    initial begin
        link_pll_vco_clock = 1'b0;
        forever #(VCO_HALF) link_pll_vco_clock = ~link_pll_vco_clock;
    end

    initial begin
        always_on_oscillator = 1'b0;
        forever #(AON_HALF) always_on_oscillator = ~always_on_oscillator;
    end

    initial begin
        falls = 0;
        peer_bit_clock = 1'b0;
        peer_word_select = 1'b0;
        forever begin
            #(BCLK_HALF);
            // clock stands still while the port is master
            if (!bit_clock_oe && !word_select_pin_oe) begin
                peer_bit_clock = ~peer_bit_clock;
                if (!peer_bit_clock) begin
                    falls = falls + 1;
                    if (falls == 32) begin
                        falls = 0;
                        peer_word_select = ~peer_word_select;
                    end
                end
            end
        end
    end
endmodule : audio_peer_model

// ### bench/tb.sv
`timescale 1ns/1ps
`include "audio_clock_params.svh"
module tb;
    import audio_clock_pkg::*;
    logic sys_clk, srst, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, err;
    logic link_pll_vco_clock, always_on_oscillator;
    logic bit_clock_out, bit_clock_oe, master_clock_out;
    logic word_select_pin_out, word_select_pin_oe;
    logic peer_bit_clock, peer_word_select;
    wire logic bclk_wire = bit_clock_oe ? bit_clock_out : peer_bit_clock;
    wire logic ws_wire = word_select_pin_oe ? word_select_pin_out
                                            : peer_word_select;
    int mismatches, checked, n;
    int ratio_of [4] = '{4, 2, 1, 8};

    audio_clock_gen_cleaner u_dut (
        .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .link_pll_vco_clock(link_pll_vco_clock),
        .always_on_oscillator(always_on_oscillator),
        .bit_clock_in(bclk_wire), .bit_clock_out(bit_clock_out),
        .bit_clock_oe(bit_clock_oe), .word_select_pin_in(ws_wire),
        .word_select_pin_out(word_select_pin_out),
        .word_select_pin_oe(word_select_pin_oe),
        .master_clock_out(master_clock_out)
    );

    audio_peer_model u_peer (
        .bit_clock_oe(bit_clock_oe), .word_select_pin_oe(word_select_pin_oe),
        .link_pll_vco_clock(link_pll_vco_clock),
        .always_on_oscillator(always_on_oscillator),
        .peer_bit_clock(peer_bit_clock), .peer_word_select(peer_word_select)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // request held until the edge that samples pready high; data taken there
    task automatic apb(input logic wr, input logic [5:0] idx,
                       input logic [7:0] wd);
        int w;
        w = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            w++;
        end while (pready !== 1'b1 && w < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w >= 50) check(32'(w), 32'h0);
    endtask : apb

    task automatic reg_is(input logic [5:0] idx, input logic [7:0] exp,
                          input logic exp_err);
        apb(1'b0, idx, 8'h00);
        check(rd, {24'h0, exp});
        check(32'(err), 32'(exp_err));
    endtask : reg_is

    function automatic logic [4:0] probe();
        return {always_on_oscillator, link_pll_vco_clock,
                word_select_pin_out, bit_clock_out, master_clock_out};
    endfunction : probe

    // counts edges of one probe between two events of another; the first
    // window is thrown away since it may straddle a configuration change
    task automatic span(input int win, input int cnt, input logic fall_cnt,
                        input logic any_win, output int num);
        logic [4:0] p, q;
        int hits, guard;
        num = 0;
        hits = 0;
        guard = 0;
        @(negedge sys_clk);
        p = probe();
        while (hits < 3 && guard < 20000) begin
            @(negedge sys_clk);
            q = probe();
            guard++;
            if (hits == 2 && q[cnt] != p[cnt] && q[cnt] == !fall_cnt) num++;
            if (q[win] != p[win] && (any_win || q[win])) hits++;
            p = q;
        end
        if (guard >= 20000) check(32'(guard), 32'h0);
    endtask : span

    initial begin
        #2000000;
        mismatches++;
        $display("ERROR %0t: watchdog expired", $time);
        give_verdict();
    end

    // ----------------------------------------------------------
    // tests
    // ----------------------------------------------------------
    initial begin
        mismatches = 0;
        checked = 0;
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        @(negedge sys_clk);
        check(32'(bit_clock_oe | word_select_pin_oe), 32'h0);
        for (int i = 0; i < 8; i++) begin
            reg_is(6'h30 + 6'(i), 8'h00, 1'b0);
        end
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, 6'h30 + 6'(i), 8'h5a ^ 8'(i * 17));
        end
        for (int i = 0; i < 7; i++) begin
            reg_is(6'h30 + 6'(i), 8'h5a ^ 8'(i * 17), 1'b0);
        end
        apb(1'b1, `IDX_CLOCK_CONTROL, 8'h18);
        repeat (8) @(negedge sys_clk);
        check(32'({bit_clock_oe, word_select_pin_oe}), 32'h0);
        check(32'({bit_clock_out, master_clock_out}), 32'h0);
        apb(1'b1, `IDX_FIFO_STATUS, 8'hff);
        reg_is(`IDX_FIFO_STATUS, 8'h00, 1'b0);
        reg_is(6'h38, 8'h00, 1'b1);
        apb(1'b1, 6'h2f, 8'h77);
        check(32'(err), 32'h1);
        // cts and n back to zero so the reference drives the port directly
        for (int i = 1; i < 7; i++) apb(1'b1, 6'h30 + 6'(i), 8'h00);
        // master on the always-on oscillator, every ratio code
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, `IDX_CLOCK_CONTROL, {1'b0, 2'(r), 2'h3, 2'h0, 1'b1});
            // enables follow one edge after the edge that takes the write
            repeat (2) @(negedge sys_clk);
            check(32'({bit_clock_oe, word_select_pin_oe}), 32'h3);
            span(1, 0, 1'b0, 1'b0, n);
            check(32'(n), 32'(ratio_of[r]));
        end
        for (int f = 0; f < 2; f++) begin
            apb(1'b1, `IDX_CLOCK_CONTROL, {1'(f), 2'h2, 2'h3, 2'h0, 1'b1});
            span(2, 1, 1'b1, 1'b1, n);
            check(32'(n), f ? 32'd16 : 32'd32);
        end
        for (int d = 0; d < 3; d++) begin
            apb(1'b1, `IDX_CLOCK_CONTROL, {1'b0, 2'h2, 2'(d), 2'h0, 1'b1});
            span(0, 3, 1'b0, 1'b0, n);
            check(32'(n), 32'(16 >> d));
        end
        // n = 0x10000, cts = 0x20000: one tick per two references
        apb(1'b1, `IDX_N_TOP_FILTER, 8'hf1);
        apb(1'b1, `IDX_CTS_BYTE2, 8'h02);
        apb(1'b1, `IDX_CLOCK_CONTROL, 8'h59);
        span(0, 4, 1'b0, 1'b0, n);
        check(32'(n), 32'd4);
        // cleaner ratio 4 at x8, zero filter shift: four references a period
        apb(1'b1, `IDX_CTS_BYTE2, 8'h00);
        apb(1'b1, `IDX_N_TOP_FILTER, 8'h00);
        apb(1'b1, `IDX_CLOCK_CONTROL, 8'h7f);
        repeat (600) @(posedge sys_clk);
        span(1, 4, 1'b0, 1'b0, n);
        check(32'(n >= 3 && n <= 5), 32'h1);
        apb(1'b0, `IDX_FIFO_STATUS, 8'h00);
        check(32'(rd[31:6]), 32'h0);
        give_verdict();
    end
endmodule : tb
